// ==== logic/ccdt_top.v ====
// Shift-gate timing and pixel clock control with paged APB registers
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ccdt_defs.vh"
module ccdt_top (
	input  wire        core_clk_i,
	input  wire        rstn_i,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Converter path
	input  wire [2:0]  operating_mode_i,
	input  wire        color5_line_i,
	input  wire        adc_valid_i,
	input  wire [15:0] adc_data_i,
	output wire        adc_corr_valid_o,
	output wire [15:0] adc_corr_data_o,
	// Sensor timing
	input  wire        external_shift_trigger_i,
	output reg         shift_gate_pulse_o,
	output reg         shift_gate_pulse_oe_o,
	output wire        pixel_clock_first_o,
	output wire        pixel_clock_second_o
);
	// Register selects
	// Three bits cover every mapped register and the refused case
	localparam SEL_NONE   = 3'd0;
	localparam SEL_C5     = 3'd1;
	localparam SEL_PAGE   = 3'd2;
	localparam SEL_MODE   = 3'd3;
	localparam SEL_WIDTH  = 3'd4;
	localparam SEL_PIX    = 3'd5;
	localparam SEL_PER_LO = 3'd6;
	localparam SEL_PER_HI = 3'd7;

	// Shift-gate sequencer states, one-hot
	localparam ST_IDLE  = 2'b01;
	localparam ST_PULSE = 2'b10;

	// Software registers
	// All eight bits wide; the master period spans two of them
	reg  [7:0]  c5_offset_q;     // Fifth-colour offset, bit 7 unused
	reg  [7:0]  page_q;          // Current register page
	reg  [7:0]  shift_gate_mode_q;       // Shift-gate mode
	reg  [7:0]  sh_width_q;      // Shift-gate width code
	reg  [7:0]  pix_ctrl_q;      // Pixel clock 1/2 control
	reg  [15:0] sh_period_q;     // Master period in ticks

	// Bus decode
	// Index is the word number; the low two address bits must be zero
	wire [7:0]  idx;             // Register index from the byte address
	wire        idx_ok;          // Address is word aligned and in range
	wire [2:0]  sel;             // Decoded register
	wire        acc;             // Access phase awaiting answer

	// Timing state
	// Tick, period and pulse counters all run on the one core clock
	reg  [3:0]  div_q;           // Tick divider
	reg         tick_q;          // One-cycle timing-unit pulse
	reg  [15:0] per_cnt_q;       // Master period counter
	reg  [8:0]  width_cnt_q;     // Ticks left in the pulse
	reg  [1:0]  state_q;         // Sequencer state
	reg         trig_q;          // Last trigger level for edge detect
	wire        trig_rise;       // Trigger rising edge
	wire        master;          // Master mode selected
	wire        start;           // Start of a new shift-gate pulse
	wire        sh_active;       // Shift-gate pulse is high
	wire [8:0]  width_ticks;     // Pulse length in ticks
	wire [1:0]  out_mode;        // Output mode field
	wire        c5_en;           // Offset applies to this sample
	wire [1:0]  pix_out;         // Pixel clock outputs

	// Decode index and page into a register select; used for read and write
	function [2:0] reg_sel;
		input [7:0] f_idx;
		input [7:0] f_page;
		begin
			// Anything not matched below is refused with an error
			reg_sel = SEL_NONE;
			if (f_idx == `CCDT_IDX_PAGE_SEL) begin
				// Page select reachable from every page
				reg_sel = SEL_PAGE;
			end else if (f_page == `CCDT_PAGE_ONE) begin
				// Page one holds only the colour-5 offset
				if (f_idx == `CCDT_IDX_C5_OFFSET) begin
					reg_sel = SEL_C5;
				end
			end else if (f_page == `CCDT_PAGE_TWO) begin
				// Page two holds the timing controls
				case (f_idx)
					`CCDT_IDX_SHIFT_GATE_MODE:      reg_sel = SEL_MODE;
					`CCDT_IDX_SH_WIDTH:     reg_sel = SEL_WIDTH;
					`CCDT_IDX_PIX12_CTRL:   reg_sel = SEL_PIX;
					`CCDT_IDX_SH_PERIOD_LO: reg_sel = SEL_PER_LO;
					`CCDT_IDX_SH_PERIOD_HI: reg_sel = SEL_PER_HI;
					default:                reg_sel = SEL_NONE;
				endcase
			end
		end
	endfunction

	assign idx    = paddr[9:2];
	assign idx_ok = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h00_0000);
	assign sel    = idx_ok ? reg_sel(idx, page_q) : SEL_NONE;
	// Decode is combinational; the answer itself is registered below
	// One wait state: answer comes on the second access-phase edge
	assign acc    = psel & penable & ~pready;

	// Register writes, taken only at the answering edge
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			c5_offset_q <= `CCDT_RST_C5_OFFSET;
			page_q      <= `CCDT_RST_PAGE_SEL;
			shift_gate_mode_q   <= `CCDT_RST_SHIFT_GATE_MODE;
			sh_width_q  <= `CCDT_RST_SH_WIDTH;
			pix_ctrl_q  <= `CCDT_RST_PIX12_CTRL;
			sh_period_q <= `CCDT_RST_SH_PERIOD;
		end else if (psel && penable && pready && pwrite) begin
			// Refused writes decode to none and change nothing
			case (sel)
				// Unused top bit of the offset always reads zero
				SEL_C5:     c5_offset_q       <= {1'b0, pwdata[6:0]};
				SEL_PAGE:   page_q            <= pwdata[7:0];
				// Timing controls take the whole byte
				SEL_MODE:   shift_gate_mode_q         <= pwdata[7:0];
				SEL_WIDTH:  sh_width_q        <= pwdata[7:0];
				SEL_PIX:    pix_ctrl_q        <= pwdata[7:0];
				// Period halves land one at a time, so a master pulse may
				// briefly see a mixed period; set master mode last to avoid it
				SEL_PER_LO: sh_period_q[7:0]  <= pwdata[7:0];
				SEL_PER_HI: sh_period_q[15:8] <= pwdata[7:0];
				// Unmapped: hold everything
				default:    page_q            <= page_q;
			endcase
		end
	end

	// APB answer: pready, read data and error all from flip-flops
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			// Answer one cycle after the access phase opens
			pready  <= acc;
			// Unmapped or misaligned addresses answer with an error
			pslverr <= acc & (sel == SEL_NONE);
			// Read data stand only in the answer cycle; zero elsewhere
			if (acc && !pwrite) begin
				case (sel)
					SEL_C5:     prdata <= {24'h00_0000, c5_offset_q};
					SEL_PAGE:   prdata <= {24'h00_0000, page_q};
					SEL_MODE:   prdata <= {24'h00_0000, shift_gate_mode_q};
					SEL_WIDTH:  prdata <= {24'h00_0000, sh_width_q};
					SEL_PIX:    prdata <= {24'h00_0000, pix_ctrl_q};
					SEL_PER_LO: prdata <= {24'h00_0000, sh_period_q[7:0]};
					SEL_PER_HI: prdata <= {24'h00_0000, sh_period_q[15:8]};
					// Refused reads return zero
					default:    prdata <= 32'h0000_0000;
				endcase
			end else begin
				// Idle or write cycle
				prdata <= 32'h0000_0000;
			end
		end
	end

	// Timing-unit divider: one pulse every few core cycles
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_q  <= 4'h0;
			tick_q <= 1'b0;
		end else if (div_q == `CCDT_TICK_DIV - 4'h1) begin
			// Last count: wrap and emit the tick
			div_q  <= 4'h0;
			tick_q <= 1'b1;
		end else begin
			// Keep counting, no tick
			div_q  <= div_q + 4'h1;
			tick_q <= 1'b0;
		end
	end

	assign trig_rise   = external_shift_trigger_i & ~trig_q;
	assign master      = shift_gate_mode_q[`CCDT_SH_MASTER_BIT];
	// A start while a pulse runs is dropped by the sequencer
	// master period wrap
	assign start       = master ? (tick_q && per_cnt_q == 16'h0000) : trig_rise;
	// A width code of zero still gives a one-tick pulse
	// width is 2n+1 ticks
	assign width_ticks = {sh_width_q, 1'b1};
	// Internal interval; it also gates the pixel clocks
	assign sh_active   = state_q[1];
	// Bits 3:0 of the mode register are kept and read back but unused
	assign out_mode    = shift_gate_mode_q[`CCDT_SH_OUTMODE_HI:`CCDT_SH_OUTMODE_LO];

	// Trigger level history; input is already synchronous
	// Resets low like an idle trigger, so no false edge follows reset
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			trig_q <= 1'b0;
		end else begin
			trig_q <= external_shift_trigger_i;
		end
	end

	// Master period counter; held at zero in slave mode so the first pulse is prompt
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			per_cnt_q <= 16'h0000;
		end else if (!master) begin
			// Slave mode: parked at zero
			per_cnt_q <= 16'h0000;
		end else if (tick_q) begin
			if (per_cnt_q == 16'h0000) begin
				// Reload; a period shorter than the width shortens nothing
				per_cnt_q <= sh_period_q - 16'h0001;
			end else begin
				// Count down toward the next pulse
				per_cnt_q <= per_cnt_q - 16'h0001;
			end
		end
	end

	// Shift-gate sequencer; a start while a pulse runs is ignored
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q     <= ST_IDLE;
			width_cnt_q <= 9'h000;
		end else begin
			case (state_q)
				ST_IDLE: begin
					// Wait for a trigger edge or a period wrap
					if (start) begin
						state_q     <= ST_PULSE;
						// Load the pulse length in ticks
						width_cnt_q <= width_ticks;
					end
				end
				ST_PULSE: begin
					// Pulse high; the count only moves on ticks
					if (tick_q) begin
						if (width_cnt_q == 9'h001) begin
							// Last tick of the pulse
							state_q <= ST_IDLE;
						end
						width_cnt_q <= width_cnt_q - 9'h001;
					end
				end
				default: begin
					// Illegal state: recover to idle
					state_q     <= ST_IDLE;
					width_cnt_q <= 9'h000;
				end
			endcase
		end
	end

	// Shift-gate pin: forced levels and tristate
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shift_gate_pulse_o    <= 1'b0;
			shift_gate_pulse_oe_o <= 1'b0;
		end else begin
			// Both pin signals registered so the pin never glitches
			// tristate bit
			shift_gate_pulse_oe_o <= ~shift_gate_mode_q[`CCDT_SH_TRISTATE_BIT];
			case (out_mode)
				// Forced levels override the sequencer
				`CCDT_SH_OUT_LOW:  shift_gate_pulse_o <= 1'b0;
				`CCDT_SH_OUT_HIGH: shift_gate_pulse_o <= 1'b1;
				// Codes 00 and 01 both pass the generated pulse
				default:           shift_gate_pulse_o <= sh_active;
			endcase
		end
	end

	// Pixel clock generators; first output uses the upper nibble
	// Both share one tick so their edges stay aligned
	// Bit index 4*(1-gi) selects the nibble of each output
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_pix
			ccdt_pix_gen u_pix (
				.core_clk_i  (core_clk_i),
				.rstn_i      (rstn_i),
				.tick_i      (tick_q),
				.act_i       (pix_ctrl_q[4*(1-gi) + `CCDT_PIX_ACT_BIT]),
				.pol_i       (pix_ctrl_q[4*(1-gi) + `CCDT_PIX_POL_BIT]),
				.freq_i      (pix_ctrl_q[4*(1-gi) + `CCDT_PIX_FREQ_BIT]),
				.dur_sh_i    (pix_ctrl_q[4*(1-gi) + `CCDT_PIX_DURSH_BIT]),
				.sh_active_i (sh_active),
				.pix_o       (pix_out[gi])
			);
		end
	endgenerate

	assign pixel_clock_first_o  = pix_out[0];
	assign pixel_clock_second_o = pix_out[1];

	// Other modes and other lines pass samples unchanged
	// mode 1a colour 5 only
	assign c5_en = (operating_mode_i == `CCDT_MODE_1A) & color5_line_i;

	// Offset adder; output flop sits inside the leaf
	ccdt_offset_add u_off (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.en_i       (c5_en),
		.offset_i   (c5_offset_q[6:0]),
		.valid_i    (adc_valid_i),
		.data_i     (adc_data_i),
		.valid_o    (adc_corr_valid_o),
		.data_o     (adc_corr_data_o)
	);
endmodule // ccdt_top
`default_nettype wire

// ==== logic/ccdt_defs.vh ====
// Register map, field positions, reset values and timing counts of the shift-gate block
`ifndef CCDT_DEFS_VH
`define CCDT_DEFS_VH

// Register indices; byte address is four times the index
`define CCDT_IDX_C5_OFFSET    8'h13
`define CCDT_IDX_PAGE_SEL     8'h1f
`define CCDT_IDX_SHIFT_GATE_MODE      8'h00
`define CCDT_IDX_SH_WIDTH     8'h01
`define CCDT_IDX_PIX12_CTRL   8'h02
`define CCDT_IDX_SH_PERIOD_LO 8'h10
`define CCDT_IDX_SH_PERIOD_HI 8'h11

// Pages that hold the registers above
`define CCDT_PAGE_ONE         8'h01
`define CCDT_PAGE_TWO         8'h02

// Reset values
`define CCDT_RST_C5_OFFSET    8'h40
`define CCDT_RST_PAGE_SEL     8'h00
`define CCDT_RST_SHIFT_GATE_MODE      8'h00
`define CCDT_RST_SH_WIDTH     8'h27
`define CCDT_RST_PIX12_CTRL   8'hc8
`define CCDT_RST_SH_PERIOD    16'h1000

// Shift-gate mode fields
`define CCDT_SH_TRISTATE_BIT  7
`define CCDT_SH_MASTER_BIT    6
`define CCDT_SH_OUTMODE_HI    5
`define CCDT_SH_OUTMODE_LO    4
`define CCDT_SH_OUT_LOW       2'b10
`define CCDT_SH_OUT_HIGH      2'b11

// Pixel clock control fields, first output in the upper nibble
`define CCDT_PIX_ACT_BIT      3
`define CCDT_PIX_POL_BIT      2
`define CCDT_PIX_FREQ_BIT     1
`define CCDT_PIX_DURSH_BIT    0

// Operating modes of the converter path
`define CCDT_MODE_1A          3'b000
`define CCDT_MODE_1B          3'b001
`define CCDT_MODE_1C          3'b010
`define CCDT_MODE_2           3'b011
`define CCDT_MODE_3           3'b100

// Offset-binary zero of the 7-bit offset field
`define CCDT_OFFSET_ZERO      7'h40

// Core clock cycles per timing unit (pixel tick)
`define CCDT_TICK_DIV         4'h2

`endif

// ==== logic/ccdt_offset_add.v ====
// Fifth-colour digital offset adder with clamping to the converter range
`timescale 1ns/1ps
`default_nettype none
module ccdt_offset_add (
	input  wire        core_clk_i,
	input  wire        rstn_i,
	input  wire        en_i,
	input  wire [6:0]  offset_i,
	input  wire        valid_i,
	input  wire [15:0] data_i,
	output reg         valid_o,
	output reg  [15:0] data_o
);
	// Signed view of the offset and the widened sum
	wire signed [7:0]  offs_s;
	wire signed [17:0] sum_s;

	assign offs_s = $signed({1'b0, offset_i}) - $signed({1'b0, `CCDT_OFFSET_ZERO});
	assign sum_s  = $signed({2'b00, data_i}) + {{10{offs_s[7]}}, offs_s};

	// Registered result; clamps so a dark pixel never wraps to full scale
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			valid_o <= 1'b0;
			data_o  <= 16'h0000;
		end else begin
			valid_o <= valid_i;
			if (!en_i) begin
				data_o <= data_i;
			end else if (sum_s[17]) begin
				data_o <= 16'h0000;
			end else if (sum_s[16]) begin
				data_o <= 16'hffff;
			end else begin
				data_o <= sum_s[15:0];
			end
		end
	end
endmodule // ccdt_offset_add
`default_nettype wire

// ==== logic/ccdt_pix_gen.v ====
// One pixel clock output: activity, polarity, rate and behaviour during shift gate
`timescale 1ns/1ps
`default_nettype none
module ccdt_pix_gen (
	input  wire core_clk_i,
	input  wire rstn_i,
	input  wire tick_i,
	input  wire act_i,
	input  wire pol_i,
	input  wire freq_i,
	input  wire dur_sh_i,
	input  wire sh_active_i,
	output reg  pix_o
);
	reg  phase_q;   // Raw clock phase before polarity
	reg  half_q;    // Skips every other tick at half rate
	wire run;       // Output is toggling this cycle

	assign run = act_i & (~sh_active_i | dur_sh_i);

	// Phase advance; when stopped the phase parks low so restart is clean
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase_q <= 1'b0;
			half_q  <= 1'b0;
			pix_o   <= 1'b0;
		end else begin
			if (!run) begin
				phase_q <= 1'b0;
				half_q  <= 1'b0;
			end else if (tick_i) begin
				half_q <= ~half_q;
				if (!freq_i || half_q) begin
					phase_q <= ~phase_q;
				end
			end
			pix_o <= (run & phase_q) ^ pol_i;
		end
	end
endmodule // ccdt_pix_gen
`default_nettype wire

// ==== test/ccdt_top_sva.sv ====
// Port assertions for the shift-gate and pixel clock block
`timescale 1ns/1ps
`default_nettype none
module ccdt_chk (
	input wire logic        core_clk_i,
	input wire logic        rstn_i,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        shift_gate_pulse_o,
	input wire logic        shift_gate_pulse_oe_o,
	input wire logic        pixel_clock_first_o,
	input wire logic        pixel_clock_second_o
);
	logic [7:0] mode_q; // Shadow of the mode register
	logic [7:0] pix_q;  // Shadow of the pixel control
	logic [2:0] age_q;  // Cycles since the last shadow write
	wire        wr_w = psel & penable & pready & pwrite & ~pslverr;
	wire        ok_w = (age_q == 3'h7);
	// Shadows follow accepted writes; outputs lag, so checks wait to settle
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_q <= 8'h00;
			pix_q  <= 8'hc8;
			age_q  <= 3'h0;
		end else begin
			age_q <= ok_w ? age_q : age_q + 3'h1;
			if (wr_w && paddr[9:2] == 8'h00) begin
				mode_q <= pwdata[7:0];
				age_q  <= 3'h0;
			end
			if (wr_w && paddr[9:2] == 8'h02) begin
				pix_q <= pwdata[7:0];
				age_q <= 3'h0;
			end
		end
	end
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);
	a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("answer not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_clean: assert property (!pready || pwrite || pslverr |-> prdata == 0)
		else $error("read data not zero");
	a_sh_tristate: assert property (ok_w |-> shift_gate_pulse_oe_o == !mode_q[7])
		else $error("shift gate enable wrong");
	a_sh_forced: assert property (ok_w && mode_q[5] |-> shift_gate_pulse_o == mode_q[4])
		else $error("forced shift gate level wrong");
	a_pix_rest: assert property (ok_w && !pix_q[7] |-> pixel_clock_first_o == pix_q[6])
		else $error("first pixel rest level wrong");
	a_pixel_clock_second_rest: assert property (ok_w && !pix_q[3] |-> pixel_clock_second_o == pix_q[2])
		else $error("second pixel rest level wrong");
	a_pix_gated: assert property (ok_w && !mode_q[5] && !pix_q[4] &&
		shift_gate_pulse_o && $past(shift_gate_pulse_o, 2) |-> pixel_clock_first_o == pix_q[6])
		else $error("first pixel clock runs in shift gate");
	a_pixel_clock_second_gated: assert property (ok_w && !mode_q[5] && !pix_q[0] &&
		shift_gate_pulse_o && $past(shift_gate_pulse_o, 2) |-> pixel_clock_second_o == pix_q[2])
		else $error("second pixel clock runs in shift gate");
	c_write: cover property (wr_w);
	c_refused: cover property (pready && pslverr);
	c_pulse: cover property ($rose(shift_gate_pulse_o));
endmodule // ccdt_chk
bind ccdt_top ccdt_chk u_chk (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .shift_gate_pulse_o(shift_gate_pulse_o),
	.shift_gate_pulse_oe_o(shift_gate_pulse_oe_o), .pixel_clock_first_o(pixel_clock_first_o),
	.pixel_clock_second_o(pixel_clock_second_o));
`default_nettype wire

// ==== test/ccdt_sensor_model.sv ====
// Sensor side: trigger source and meter of shift-gate and pixel clock
`timescale 1ns/1ps
`default_nettype none
module ccdt_sensor_model (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        fire_i,
	input  wire logic        sh_i,
	input  wire logic        sh_oe_i,
	input  wire logic        pixel_clock_first_i,
	output var  logic        trig_o,
	output var  logic [15:0] width_o,
	output var  logic [15:0] pulses_o,
	output var  logic [15:0] edges_o
);
	logic        sh_q;  // Last level seen on the shift-gate line
	logic        pix_q; // Last pixel clock level
	logic [15:0] cnt_q; // Length of the running pulse
	// Released line has no pull, so it wanders instead of holding
	wire         line_w = sh_oe_i ? sh_i : ~sh_q;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{trig_o, sh_q, pix_q} <= 3'h0;
			{width_o, pulses_o, edges_o, cnt_q} <= '0;
		end else begin
			trig_o <= fire_i;
			sh_q   <= line_w;
			pix_q  <= pixel_clock_first_i;
			if (pix_q != pixel_clock_first_i)
				edges_o <= edges_o + 16'h0001;
			if (line_w && !sh_q)
				pulses_o <= pulses_o + 16'h0001;
			cnt_q <= line_w ? cnt_q + 16'h0001 : 16'h0000;
			if (!line_w && sh_q)
				width_o <= cnt_q;
		end
	end
endmodule // ccdt_sensor_model
`default_nettype wire

// ==== test/tb_ccd_sh_pixel_timing_regs.sv ====
// Self-checking bench for the shift-gate and pixel clock block
`timescale 1ns/1ps
`default_nettype none
module tb_ccd_sh_pixel_timing_regs;
	logic        core_clk_i, rstn_i, psel, penable, pwrite, color5_line_i, adc_valid_i, fire, re;
	logic [31:0] paddr, pwdata, lf, rd;
	logic [2:0]  operating_mode_i, om;
	logic [15:0] adc_data_i, dd, p0, e0;
	logic [7:0]  w;
	logic [7:0]  fm [5] = '{8'h10, 8'h20, 8'h30, 8'h80, 8'hb0};
	wire  [31:0] prdata;
	wire         pready, pslverr, cv, sh, oe, pixel_clock_first, pixel_clock_second, trig;
	wire  [15:0] cd, wid, pul, edg;
	int          errors, checks, n, x;
	ccdt_top dut (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .operating_mode_i(operating_mode_i), .color5_line_i(color5_line_i),
		.adc_valid_i(adc_valid_i), .adc_data_i(adc_data_i), .adc_corr_valid_o(cv),
		.adc_corr_data_o(cd), .external_shift_trigger_i(trig), .shift_gate_pulse_o(sh),
		.shift_gate_pulse_oe_o(oe), .pixel_clock_first_o(pixel_clock_first), .pixel_clock_second_o(pixel_clock_second));
	ccdt_sensor_model model (
		.clk_i(core_clk_i), .rstn_i(rstn_i), .fire_i(fire), .sh_i(sh), .sh_oe_i(oe),
		.pixel_clock_first_i(pixel_clock_first), .trig_o(trig), .width_o(wid), .pulses_o(pul), .edges_o(edg));
	// Core clock, 50 ns period
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Offset binary code, centre 64, clamped to the sample range
	function automatic logic [15:0] exp_off(input logic [2:0] m, input logic c,
		input logic [6:0] o, input logic [15:0] d);
		int s;
		s = int'(d) + int'(o) - 64;
		if (m != 3'h0 || !c)
			return d;
		return (s < 0) ? 16'h0000 : (s > 65535) ? 16'hffff : s[15:0];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One transfer; held until pready is seen at an edge, bounded wait
	task automatic apb(input logic wr, input logic [7:0] ix, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {22'h0, ix, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge core_clk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: no bus answer", $time);
			finish_test();
		end
		rd = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic rdc(input logic [7:0] ix, input logic [31:0] exp, input string m);
		apb(1'b0, ix, 8'h00);
		chk(rd, exp, m);
	endtask
	task automatic sample(input logic [2:0] m, input logic c, input logic [6:0] o,
		input logic [15:0] d);
		chk(cv, 0, "idle strobe");
		operating_mode_i <= m;
		color5_line_i <= c;
		adc_valid_i <= 1'b1;
		adc_data_i <= d;
		@(posedge core_clk_i);
		adc_valid_i <= 1'b0;
		@(posedge core_clk_i);
		chk(cv, 1, "sample strobe");
		chk(cd, exp_off(m, c, o, d), "corrected sample");
	endtask
	initial begin
		{rstn_i, psel, penable, pwrite, color5_line_i, adc_valid_i, fire} = 7'h00;
		{paddr, pwdata, operating_mode_i, adc_data_i} = '0;
		errors = 0;
		checks = 0;
		lf = 32'h024c_d15b;
		repeat (6) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		@(posedge core_clk_i);
		rdc(8'h1f, 0, "page reset");
		apb(1'b1, 8'h1f, 8'h01);
		rdc(8'h13, 32'h0000_0040, "offset reset");
		apb(1'b1, 8'h1f, 8'h02);
		rdc(8'h1f, 32'h0000_0002, "page readback");
		rdc(8'h00, 0, "mode reset");
		rdc(8'h01, 32'h0000_0027, "width reset");
		rdc(8'h02, 32'h0000_00c8, "pixel reset");
		rdc(8'h11, 32'h0000_0010, "period reset");
		rdc(8'h13, 0, "other page");
		chk(re, 1, "refused access");
		$display("test registers done");
		// Offset with clamp corners first, then random samples
		apb(1'b1, 8'h1f, 8'h01);
		for (int i = 0; i < 12; i++) begin
			lf = lfsr(lf);
			w = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : lf[7:0];
			om = (i < 2) ? 3'h0 : 3'(i % 5);
			dd = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : lf[31:16];
			apb(1'b1, 8'h13, w);
			rdc(8'h13, {25'h0, w[6:0]}, "offset readback");
			sample(om, (i < 2) | lf[8], w[6:0], dd);
		end
		$display("test offset done");
		// Slave pulses at both width extremes, then one random width
		apb(1'b1, 8'h1f, 8'h02);
		for (int i = 0; i < 3; i++) begin
			w = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : lf[11:4];
			// First pixel clock runs through the pulse on odd passes only
			apb(1'b1, 8'h02, {3'b100, i[0], 4'h8});
			apb(1'b1, 8'h01, w);
			p0 = pul;
			e0 = edg;
			fire <= 1'b1;
			repeat (4) @(posedge core_clk_i);
			fire <= 1'b0;
			repeat (4 * w + 24) @(posedge core_clk_i);
			chk(pul, p0 + 16'h0001, "slave pulse");
			chk(wid >= 4 * w && wid <= 4 * w + 4, 1, "pulse width");
			n = int'(edg - e0);
			x = i[0] ? 2 * w + 14 : 13;
			chk(n >= x - 3 && n <= x + 3, 1, "pixel clock in pulse");
		end
		$display("test slave done");
		// Master at 32 ticks, pixel clocks gated by the control left from the last slave pass
		apb(1'b1, 8'h10, 8'h20);
		apb(1'b1, 8'h11, 8'h00);
		apb(1'b1, 8'h01, 8'h03);
		apb(1'b1, 8'h00, 8'h40);
		p0 = pul;
		repeat (640) @(posedge core_clk_i);
		chk(pul - p0 >= 9 && pul - p0 <= 11, 1, "master pulses");
		$display("test master done");
		foreach (fm[i]) begin
			apb(1'b1, 8'h00, fm[i]);
			// Long enough for a master pulse still in flight to end
			repeat (24) @(posedge core_clk_i);
			chk(oe, !fm[i][7], "drive enable");
			chk(sh, fm[i][5] & fm[i][4], "forced level");
		end
		$display("test output modes done");
		apb(1'b1, 8'h00, 8'h00);
		for (int i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			w = {i[2:0], 1'b0, lf[3:0]};
			apb(1'b1, 8'h02, w);
			repeat (6) @(posedge core_clk_i);
			e0 = edg;
			repeat (80) @(posedge core_clk_i);
			n = int'(edg - e0);
			x = w[7] ? (w[5] ? 20 : 40) : 0;
			chk(n >= x - 1 && n <= x + 1, 1, "pixel edges");
			if (!w[7])
				chk(pixel_clock_first, w[6], "first rest");
			if (!w[3])
				chk(pixel_clock_second, w[2], "second rest");
		end
		$display("test pixel done");
		finish_test();
	end
endmodule // tb_ccd_sh_pixel_timing_regs
`default_nettype wire
